// [verilog/emif_timing_regs.svh]
// constants of the external memory timing block: sfr location, fields, reset value, fixed counts
// assumes inclusion by the package and the top module only
// Functional notes
// - timing register at 0xEE page F, resets all ones
// - bits 5:2 give strobe width code plus one
// - muxed mode: latch enable high 1-4 cycles
// - muxed mode: latch enable low 1-7 before strobe (1-4 latch low plus 0-3 setup)
// - write data valid 1-19 cycles before strobe end
// - write data held 0-3 cycles after strobe
// - mode 101/110/111: separate address and data pins
// - mode 110: bank select drives upper address byte
// - mode 001/010/011: shared data and low address
// - mode 001/011: 8-bit access leaves upper byte undriven
// - muxed pins: strobes port 6, AD port 5, high port 4
// - config bit 4 selects multiplexed or not
// - transfer lasts timings plus four cycles
// - bank mode: 8-bit access takes high from bank page, low from pointer
`ifndef EMIF_TIMING_REGS_SVH
`define EMIF_TIMING_REGS_SVH
`define TIMING_CTRL_ADDR   8'hEE
`define TIMING_CTRL_PAGE   8'h0F
`define TIMING_CTRL_RESET  8'hFF
`define SETUP_MSB          7
`define SETUP_LSB          6
`define STROBE_MSB         5
`define STROBE_LSB         2
`define HOLD_MSB           1
`define HOLD_LSB           0
`define CFG_MUX_BIT        4
`define CFG_MODE_MSB       3
`define CFG_MODE_LSB       2
`define CFG_ALE_MSB        1
`define CFG_ALE_LSB        0
`define MODE_BANK_SELECT   2'h2
`define START_CYCLES       1
`define FINISH_CYCLES      3
`endif

// [verilog/emif_timing_pkg.sv]
// types shared by the external memory timing block
// assumes the constants header sits beside it
package emif_timing_pkg;
    `include "emif_timing_regs.svh"

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_START  = 3'h1,
        ST_ALE_HI = 3'h3,
        ST_ALE_LO = 3'h2,
        ST_SETUP  = 3'h6,
        ST_STROBE = 3'h7,
        ST_HOLD   = 3'h5,
        ST_FINISH = 3'h4
    } bus_state_t;

    typedef struct packed {
        logic        write;
        logic        is_8bit;
        logic [15:0] addr;
        logic [7:0]  ptr_low;
        logic [7:0]  wdata;
    } xfer_req_t;

    typedef struct packed {
        logic [7:0] p3_out;
        logic [7:0] p3_oe;
        logic [7:0] p4_out;
        logic [7:0] p4_oe;
        logic [7:0] p5_out;
        logic [7:0] p5_oe;
        logic [2:0] p6_out;
        logic [2:0] p6_oe;
    } emif_pins_t;
endpackage

// [verilog/phase_timer.sv]
// down counter timing one bus phase
// assumes load is asserted on the cycle before the phase starts
`timescale 1ns/1ps
module phase_timer #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    output logic                  expired
);
    logic [WIDTH-1:0] count_reg;

    generate
        if (WIDTH < 4) begin : g_width_check
            $error("phase_timer width too small for strobe codes");
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= load_val;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign expired = (count_reg == '0);
endmodule // phase_timer

// [verilog/ext_memory_bus_timing.sv]
// external memory bus sequencer with programmable setup, strobe, hold and latch enable timing
// assumes requests are already known to target off-chip space; config and bank page come from outside
`timescale 1ns/1ps
`include "emif_timing_regs.svh"
module ext_memory_bus_timing #(
    parameter int TIMER_WIDTH = 4
) (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic [7:0]                  sfr_addr,
    input  wire logic [7:0]                  sfr_page,
    input  wire logic                        sfr_wr,
    input  wire logic                        sfr_rd,
    input  wire logic [7:0]                  sfr_wdata,
    output logic [7:0]                       sfr_rdata,
    input  wire logic [7:0]                  ext_mem_config,
    input  wire logic [7:0]                  ext_mem_bank_page,
    input  wire logic                        req_valid,
    output logic                             req_ready,
    input  wire emif_timing_pkg::xfer_req_t  req,
    output logic                             xfer_done,
    output logic [7:0]                       rdata,
    input  wire logic [7:0]                  p5_in,
    output emif_timing_pkg::emif_pins_t      pins
);
    import emif_timing_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // the strobe code alone needs four timer bits
    generate
        if (TIMER_WIDTH < 4) begin : g_timer_width_check
            $error("timer width too small for strobe codes");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // timing register
    logic [7:0] ext_mem_timing_control_reg;
    logic [7:0] sfr_rdata_reg;
    wire        timing_hit = (sfr_addr == `TIMING_CTRL_ADDR) && (sfr_page == `TIMING_CTRL_PAGE);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_mem_timing_control_reg <= `TIMING_CTRL_RESET;
        end else if (sfr_wr && timing_hit) begin
            ext_mem_timing_control_reg <= sfr_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata_reg <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata_reg <= timing_hit ? ext_mem_timing_control_reg : 8'h00;
        end
    end

    assign sfr_rdata = sfr_rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // snapshot taken at accept; a mid-transfer register write must not bend the strobe in flight
    bus_state_t state_reg;
    bus_state_t state_next;
    xfer_req_t  req_reg;
    xfer_req_t  req_next;
    logic [7:0] timing_reg;
    logic [7:0] timing_next;
    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic [7:0] bank_reg;
    logic [7:0] bank_next;
    logic [7:0] rdata_reg;
    emif_pins_t pins_reg;
    emif_pins_t pins_next;
    logic       expired;

    // ready is combinational so a waiting request is taken on the first idle edge
    wire accept = req_valid && (state_reg == ST_IDLE);
    assign req_ready = (state_reg == ST_IDLE);

    assign req_next    = accept ? req : req_reg;
    assign timing_next = accept ? ext_mem_timing_control_reg : timing_reg;
    assign cfg_next    = accept ? ext_mem_config : cfg_reg;
    assign bank_next   = accept ? ext_mem_bank_page : bank_reg;

    // mode decoding, applied to the captured and to the incoming configuration
    function automatic logic cfg_is_muxed(input logic [7:0] cfg);
        return !cfg[`CFG_MUX_BIT];
    endfunction

    function automatic logic cfg_is_bank(input logic [7:0] cfg);
        return cfg[`CFG_MODE_MSB:`CFG_MODE_LSB] == `MODE_BANK_SELECT;
    endfunction

    wire [1:0] setup_code  = timing_reg[`SETUP_MSB:`SETUP_LSB];
    wire [3:0] strobe_code = timing_reg[`STROBE_MSB:`STROBE_LSB];
    wire [1:0] hold_code   = timing_reg[`HOLD_MSB:`HOLD_LSB];
    wire [1:0] ale_code    = cfg_reg[`CFG_ALE_MSB:`CFG_ALE_LSB];
    wire       muxed       = cfg_is_muxed(cfg_reg);

    ////////////////////////////////////////////////////////////////////////////
    // phase lengths, as cycles minus one loaded into the timer
    function automatic logic [3:0] phase_len(input bus_state_t st);
        logic [3:0] len;
        len = 4'h0;
        unique case (st)
            ST_IDLE:   len = 4'h0;
            ST_START:  len = 4'(`START_CYCLES - 1);
            ST_ALE_HI: len = {2'h0, ale_code};
            ST_ALE_LO: len = {2'h0, ale_code};
            ST_SETUP:  len = {2'h0, setup_code - 2'h1};
            ST_STROBE: len = strobe_code;
            ST_HOLD:   len = {2'h0, hold_code - 2'h1};
            ST_FINISH: len = 4'(`FINISH_CYCLES - 1);
        endcase
        return len;
    endfunction

    wire bus_state_t after_addr   = (setup_code != 2'h0) ? ST_SETUP : ST_STROBE;
    wire bus_state_t after_strobe = (hold_code != 2'h0) ? ST_HOLD : ST_FINISH;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:   if (accept) state_next = ST_START;
            ST_START:  if (expired) state_next = muxed ? ST_ALE_HI : after_addr;
            ST_ALE_HI: if (expired) state_next = ST_ALE_LO;
            ST_ALE_LO: if (expired) state_next = after_addr;
            ST_SETUP:  if (expired) state_next = ST_STROBE;
            ST_STROBE: if (expired) state_next = after_strobe;
            ST_HOLD:   if (expired) state_next = ST_FINISH;
            ST_FINISH: if (expired) state_next = ST_IDLE;
        endcase
    end

    // every state change reloads the timer, so a phase never inherits a stale count
    wire                   timer_load = (state_next != state_reg);
    wire [TIMER_WIDTH-1:0] phase_load = TIMER_WIDTH'(phase_len(state_next));

    phase_timer #(
        .WIDTH (TIMER_WIDTH)
    ) u_phase_timer (
        .clk      (clk),
        .reset_n  (reset_n),
        .load     (timer_load),
        .load_val (phase_load),
        .expired  (expired)
    );

    assign xfer_done = (state_reg == ST_FINISH) && expired;

    ////////////////////////////////////////////////////////////////////////////
    // pin image for the next cycle, registered so the pins never glitch
    wire       nx_busy   = (state_next != ST_IDLE);
    wire       nx_muxed  = cfg_is_muxed(cfg_next);
    wire       nx_addr   = (state_next == ST_START) || (state_next == ST_ALE_HI) || (state_next == ST_ALE_LO);
    wire       nx_data   = (state_next == ST_SETUP) || (state_next == ST_STROBE) || (state_next == ST_HOLD);
    wire       nx_bank   = cfg_is_bank(cfg_next);
    wire       nx_hi_en  = nx_busy && (!req_next.is_8bit || nx_bank);
    wire [7:0] nx_hi     = req_next.is_8bit ? bank_next : req_next.addr[15:8];
    wire [7:0] nx_lo     = req_next.is_8bit ? req_next.ptr_low : req_next.addr[7:0];
    wire       nx_wr_dat = nx_data && req_next.write;
    wire       nx_strobe = (state_next == ST_STROBE);

    always_comb begin
        pins_next = '0;
        pins_next.p6_out = {(state_next == ST_ALE_HI), !(nx_strobe && !req_next.write),
                            !(nx_strobe && req_next.write)};
        pins_next.p6_oe  = {nx_muxed, 2'h3};
        if (nx_muxed) begin
            // latch passes the address while enable is high and holds it once it falls
            pins_next.p5_out = nx_addr ? nx_lo : req_next.wdata;
            pins_next.p5_oe  = {8{nx_addr || nx_wr_dat}};
            pins_next.p4_out = nx_hi;
            pins_next.p4_oe  = {8{nx_hi_en}};
        end else begin
            pins_next.p5_out = req_next.wdata;
            pins_next.p5_oe  = {8{nx_wr_dat}};
            pins_next.p4_out = nx_lo;
            pins_next.p4_oe  = {8{nx_busy}};
            pins_next.p3_out = nx_hi;
            pins_next.p3_oe  = {8{nx_hi_en}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state and capture registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg  <= ST_IDLE;
            req_reg    <= '0;
            timing_reg <= `TIMING_CTRL_RESET;
            cfg_reg    <= 8'h00;
            bank_reg   <= 8'h00;
        end else begin
            state_reg  <= state_next;
            req_reg    <= req_next;
            timing_reg <= timing_next;
            cfg_reg    <= cfg_next;
            bank_reg   <= bank_next;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // strobes idle high and latch enable undriven straight out of reset
            pins_reg <= '{p6_out: 3'h3, p6_oe: 3'h3, default: '0};
        end else begin
            pins_reg <= pins_next;
        end
    end

    // read data taken on the last strobe cycle, the latest point the memory is still enabled
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= 8'h00;
        end else if ((state_reg == ST_STROBE) && expired && !req_reg.write) begin
            rdata_reg <= p5_in;
        end
    end

    assign rdata = rdata_reg;
    assign pins  = pins_reg;
endmodule // ext_memory_bus_timing

// [bench/emif_assertions.sv]
// port checker for the bus sequencer
// assumes bind from tb, idle-only register and config changes
`timescale 1ns/1ps
module emif_assertions import emif_timing_pkg::*; (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [7:0] ext_mem_config,
    input wire logic       req_valid,
    input wire logic       req_ready,
    input wire logic       xfer_done,
    input wire emif_timing_pkg::emif_pins_t pins
);
    logic [7:0] tc_reg;
    logic [4:0] ale_cnt;
    logic [4:0] stb_cnt;
    logic [4:0] wr_cnt;
    logic [4:0] gap_cnt;
    wire        hit = sfr_addr == 8'hEE && sfr_page == 8'h0F;
    wire        stb = !pins.p6_out[0] || !pins.p6_out[1];
    wire        ale = pins.p6_out[2];
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tc_reg <= 8'hFF;
            ale_cnt <= 5'h0;
            stb_cnt <= 5'h0;
            wr_cnt <= 5'h1F;
            gap_cnt <= 5'h0;
        end else begin
            if (sfr_wr && hit)
                tc_reg <= sfr_wdata;
            ale_cnt <= ale ? ale_cnt + 5'h1 : 5'h0;
            stb_cnt <= stb ? stb_cnt + 5'h1 : 5'h0;
            // saturates so an old write never looks like a fresh hold
            wr_cnt <= !pins.p6_out[0] ? 5'h0 : (wr_cnt == 5'h1F ? wr_cnt : wr_cnt + 5'h1);
            // cycles since latch enable was last high, saturating
            gap_cnt <= ale ? 5'h0 : (gap_cnt == 5'h1F ? gap_cnt : gap_cnt + 5'h1);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_rd_miss; sfr_rd && !hit |=> sfr_rdata == 8'h00; endproperty
    a_rd_miss: assert property (p_rd_miss) else $error("unmapped read not zero");
    property p_stb; $fell(stb) |-> stb_cnt == tc_reg[5:2] + 5'h1; endproperty
    a_stb: assert property (p_stb) else $error("strobe width");
    property p_ale; $fell(ale) |-> ale_cnt == ext_mem_config[1:0] + 5'h1; endproperty
    a_ale: assert property (p_ale) else $error("latch enable width");
    property p_ale_lo; $fell(ale) |-> !stb; endproperty
    a_ale_lo: assert property (p_ale_lo) else $error("strobe at latch fall");
    property p_wdat; !pins.p6_out[0] |-> pins.p5_oe == 8'hFF; endproperty
    a_wdat: assert property (p_wdat) else $error("write data not driven");
    property p_hold; $fell(pins.p5_oe[0]) && wr_cnt <= 5'h3 |-> wr_cnt == {3'h0, tc_reg[1:0]}; endproperty
    a_hold: assert property (p_hold) else $error("write hold");
    property p_busy; req_valid && req_ready |=> (!req_ready) [*4]; endproperty
    a_busy: assert property (p_busy) else $error("short transfer");
    property p_done; xfer_done |-> !req_ready ##1 (req_ready && !xfer_done); endproperty
    a_done: assert property (p_done) else $error("done pulse");
    property p_gap;
        $rose(stb) && !ext_mem_config[4] |-> gap_cnt == {3'h0, ext_mem_config[1:0]} + {3'h0, tc_reg[7:6]} + 5'h1;
    endproperty
    a_gap: assert property (p_gap) else $error("latch low or setup width");
    property p_addr_oe; stb && ext_mem_config[4] |-> pins.p4_oe == 8'hFF; endproperty
    a_addr_oe: assert property (p_addr_oe) else $error("low address not driven");
    property p_ale_ad; ale |-> pins.p5_oe == 8'hFF && pins.p6_oe[2]; endproperty
    a_ale_ad: assert property (p_ale_ad) else $error("address not driven in latch phase");
    cover property ($fell(ale));
    cover property ($fell(pins.p6_out[0]));
    cover property ($fell(pins.p6_out[1]));
endmodule // emif_assertions

// [bench/sram_model.sv]
// external sram with low address latch
// assumes muxed tells which pinout is in use
`timescale 1ns/1ps
module sram_model import emif_timing_pkg::*; (
    input wire logic        clk,
    input wire logic        muxed,
    input wire emif_timing_pkg::emif_pins_t pins,
    output logic [7:0]      p5_in,
    output logic [15:0]     a_seen
);
    logic [7:0] mem [0:65535];
    logic [7:0] lat = 8'h00;
    logic [7:0] last = 8'h5A;
    // undriven high byte reads as zero
    wire [7:0]  hi = muxed ? pins.p4_out & pins.p4_oe : pins.p3_out & pins.p3_oe;
    wire [7:0]  lo = muxed ? lat : pins.p4_out;
    wire [15:0] ad = {hi, lo};
    // released bus toggles so a stale value cannot pass
    assign p5_in = !pins.p6_out[1] ? mem[ad] : ~last;
    always @(posedge clk) begin
        last <= p5_in;
        if (pins.p6_out[2] && pins.p6_oe[2])
            lat <= pins.p5_out;
        if (!pins.p6_out[0])
            mem[ad] <= pins.p5_out;
        if (!pins.p6_out[0] || !pins.p6_out[1])
            a_seen <= ad;
    end
endmodule // sram_model

// [bench/tb.sv]
// self-checking bench for the bus sequencer
// assumes sram model and checker beside it
`timescale 1ns/1ps
module tb;
    import emif_timing_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, req_valid = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_page = 8'h00, sfr_wdata = 8'h00, cfg = 8'h00, bank = 8'h00;
    logic [7:0] sfr_rdata, rdata, p5_in, tc, shadow [0:65535];
    logic [15:0] a_seen;
    logic req_ready, xfer_done;
    xfer_req_t req = '0;
    emif_pins_t pins;
    int n_mismatch = 0, num_checks = 0, seed = 32'hEC09D4A9;
    always #12.5 clk = ~clk;
    ext_memory_bus_timing dut_u (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ext_mem_config(cfg),
        .ext_mem_bank_page(bank), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .xfer_done(xfer_done), .rdata(rdata), .p5_in(p5_in), .pins(pins));
    sram_model mem_u (.clk(clk), .muxed(!cfg[4]), .pins(pins), .p5_in(p5_in), .a_seen(a_seen));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // four cycles of overhead, strobe code plus one, two latch phases of code plus one when muxed
    function automatic int exp_len(input logic [7:0] t, input logic [7:0] c);
        return 5 + t[7:6] + t[5:2] + t[1:0] + (c[4] ? 0 : 2 * (c[1:0] + 1));
    endfunction
    // 8-bit accesses take the bank page only in bank select mode, otherwise the undriven byte reads zero
    function automatic logic [15:0] exp_addr(input logic b8, input logic [15:0] a, input logic [7:0] p,
                                             input logic [7:0] c, input logic [7:0] bk);
        return b8 ? {c[3:2] == 2'h2 ? bk : 8'h00, p} : a;
    endfunction
    task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] pg, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_page <= pg;
        sfr_wdata <= d;
        sfr_wr <= w;
        sfr_rd <= !w;
        @(posedge clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        @(negedge clk);
    endtask
    task automatic xfer(input logic w, input logic b8, input logic [15:0] a, input logic [7:0] p,
                        input logic [7:0] d);
        int c;
        logic [15:0] ea;
        c = 0;
        ea = exp_addr(b8, a, p, cfg, bank);
        @(posedge clk);
        req <= '{w, b8, a, p, d};
        req_valid <= 1'b1;
        @(negedge clk);
        while (req_ready !== 1'b1)
            @(negedge clk);
        @(posedge clk);
        req_valid <= 1'b0;
        do begin
            @(negedge clk);
            c++;
        end while (xfer_done !== 1'b1 && c < 100);
        chk(c, exp_len(tc, cfg), "length");
        chk(a_seen, ea, "address");
        if (w)
            shadow[ea] = d;
        else
            chk(rdata, shadow[ea], "read data");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        results();
    end
    initial begin
        logic [15:0] a;
        logic [7:0] p;
        logic [7:0] d;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        sfr(1'b0, 8'hEE, 8'h0F, 8'h00);
        chk(sfr_rdata, 8'hFF, "reset value");
        sfr(1'b1, 8'hEE, 8'h00, 8'h12);
        sfr(1'b0, 8'hEE, 8'h00, 8'h00);
        chk(sfr_rdata, 8'h00, "unmapped read");
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            cfg <= {3'h0, i[0], 2'(i % 3 + 1), 2'($random(seed))};
            bank <= 8'($random(seed));
            tc = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
            sfr(1'b1, 8'hEE, 8'h0F, tc);
            sfr(1'b0, 8'hEE, 8'h0F, 8'h00);
            chk(sfr_rdata, tc, "timing register");
            a = 16'($random(seed));
            p = 8'($random(seed));
            d = 8'($random(seed));
            xfer(1'b1, 1'((i / 6) % 2), a, p, d);
            xfer(1'b0, 1'((i / 6) % 2), a, p, 8'h00);
        end
        results();
    end
endmodule // tb
bind ext_memory_bus_timing emif_assertions chk_u (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
    .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .ext_mem_config(ext_mem_config), .req_valid(req_valid), .req_ready(req_ready), .xfer_done(xfer_done),
    .pins(pins));
